/* File: design/exec_pkg.sv */
// Purpose: Constants and types shared by the literal/file/bit execute block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file address
// Notes on behaviour
// - Literal add: accumulator plus literal into accumulator, carry, nibble carry, zero.
// - Literal AND: accumulator AND literal into accumulator, zero flag only.
// - File AND: accumulator AND addressed file register, zero flag only.
// - File add: accumulator plus addressed file register, carry, nibble carry, zero.
// - Target bit zero writes accumulator; one writes back the file register.
// - Bit clear forces selected file bit to zero, flags untouched.
// - Bit set forces selected file bit to one, flags untouched.
package exec_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int BIT_W   = 3;
  localparam int FILE_DEPTH = 128;
  localparam logic [4:0] PAT_ADD_LIT = 5'h1f;
  localparam logic [5:0] PAT_AND_LIT = 6'h39;
  localparam logic [5:0] PAT_AND_FILE = 6'h05;
  localparam logic [5:0] PAT_ADD_FILE = 6'h07;
  localparam logic [3:0] PAT_CLR_BIT = 4'h4;
  localparam logic [3:0] PAT_SET_BIT = 4'h5;
  localparam logic [3:0] PAT_TST_BIT = 4'h6;
  localparam int TGT_POS = 7;
  localparam int BSEL_LSB = 7;
  localparam int NIB_W = 4;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  typedef enum logic [2:0] {
    op_none, op_add_lit, op_and_lit, op_and_file, op_add_file, op_clr_bit, op_set_bit,
    op_tst_bit
  } op_t;
  typedef enum logic {st_run, st_flush} state_t;
endpackage

/* File: design/exec_if.sv */
// Purpose: Decoded operation from decoder to execute core
// Assumes: Single clock
// Notes: Combinational carrier
`timescale 1ns/1ps
interface exec_if;
  import exec_pkg::*;
  op_t                op;
  logic [DATA_W-1:0]  lit;
  logic [ADDR_W-1:0]  addr;
  logic [BIT_W-1:0]   bsel;
  logic               tgt_file;
  modport src (output op, lit, addr, bsel, tgt_file);
  modport dst (input op, lit, addr, bsel, tgt_file);
endinterface

/* File: design/instr_decode.sv */
// Purpose: Pattern match of one instruction word
// Assumes: Word valid with instr_valid
// Notes: Unknown words decode to no operation
`timescale 1ns/1ps
module instr_decode
  import exec_pkg::*;
(
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic               instr_valid,
  exec_if.src                     dec
);
  wire m_add_lit  = instr[INSTR_W-1 -: $bits(PAT_ADD_LIT)] == PAT_ADD_LIT;
  wire m_and_lit  = instr[INSTR_W-1 -: $bits(PAT_AND_LIT)] == PAT_AND_LIT;
  wire m_and_file = instr[INSTR_W-1 -: $bits(PAT_AND_FILE)] == PAT_AND_FILE;
  wire m_add_file = instr[INSTR_W-1 -: $bits(PAT_ADD_FILE)] == PAT_ADD_FILE;
  wire m_clr_bit  = instr[INSTR_W-1 -: $bits(PAT_CLR_BIT)] == PAT_CLR_BIT;
  wire m_set_bit  = instr[INSTR_W-1 -: $bits(PAT_SET_BIT)] == PAT_SET_BIT;
  wire m_tst_bit  = instr[INSTR_W-1 -: $bits(PAT_TST_BIT)] == PAT_TST_BIT;
  assign dec.op = !instr_valid ? op_none :
                  m_add_lit  ? op_add_lit  :
                  m_and_lit  ? op_and_lit  :
                  m_and_file ? op_and_file :
                  m_add_file ? op_add_file :
                  m_clr_bit  ? op_clr_bit  :
                  m_set_bit  ? op_set_bit  :
                  m_tst_bit  ? op_tst_bit  : op_none;
  assign dec.lit      = instr[DATA_W-1:0];
  assign dec.addr     = instr[ADDR_W-1:0];
  assign dec.bsel     = instr[BSEL_LSB+BIT_W-1:BSEL_LSB];
  assign dec.tgt_file = instr[TGT_POS];
endmodule

/* File: design/literal_file_bit_instr_exec.sv */
// Purpose: Execute literal, file and bit instructions on accumulator, file, flags
// Assumes: One instruction word per cycle from the fetch path
// Notes: File registers are flip-flops; all outputs registered
`timescale 1ns/1ps
module literal_file_bit_instr_exec
  import exec_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic               instr_valid,
  output logic      [DATA_W-1:0]  accumulator,
  output logic                    overflow_out_bit,
  output logic                    nibble_carry,
  output logic                    result_null_flag,
  output logic                    skip_active,
  output logic                    instr_done
);
  exec_if dec_bus ();
  state_t             state;
  logic [DATA_W-1:0]  file_reg [FILE_DEPTH];

  instr_decode u_dec (
    .instr       (instr),
    .instr_valid (instr_valid && state == st_run),
    .dec         (dec_bus.src)
  );

  wire op_t              op      = dec_bus.op;
  wire logic [DATA_W-1:0] fval   = file_reg[dec_bus.addr];
  wire logic [DATA_W-1:0] opnd   = (op == op_add_lit || op == op_and_lit) ? dec_bus.lit : fval;
  wire logic              is_add = op == op_add_lit || op == op_add_file;
  wire logic              is_and = op == op_and_lit || op == op_and_file;
  wire logic [DATA_W:0]   sum    = {1'b0, accumulator} + {1'b0, opnd};
  wire logic [NIB_W:0]    nsum   = {1'b0, accumulator[NIB_W-1:0]} + {1'b0, opnd[NIB_W-1:0]};
  wire logic [DATA_W-1:0] result = is_add ? sum[DATA_W-1:0] : accumulator & opnd;
  wire logic              is_file_op = op == op_and_file || op == op_add_file;
  wire logic              wr_acc  = (is_add || is_and) && !(is_file_op && dec_bus.tgt_file);
  wire logic              wr_file_res = is_file_op && dec_bus.tgt_file;
  wire logic [DATA_W-1:0] bit_mask = DATA_W'(1) << dec_bus.bsel;
  wire logic [DATA_W-1:0] bit_val  = (op == op_set_bit) ? (fval | bit_mask)
                                                        : (fval & ~bit_mask);
  wire logic              wr_bit   = op == op_clr_bit || op == op_set_bit;
  wire logic              skip_now = op == op_tst_bit && !fval[dec_bus.bsel];
  wire state_t            next_state = skip_now ? st_flush : st_run;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= st_run;
      skip_active <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      state <= next_state;
      skip_active <= skip_now;
      instr_done <= instr_valid || state == st_flush;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      accumulator <= ACC_RESET;
      overflow_out_bit <= 1'b0;
      nibble_carry <= 1'b0;
      result_null_flag <= 1'b0;
    end else begin
      if (wr_acc) begin
        accumulator <= result;
      end
      if (is_add || is_and) begin
        result_null_flag <= result == '0;
      end
      if (is_add) begin
        overflow_out_bit <= sum[DATA_W];
        nibble_carry <= nsum[NIB_W];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_reg[i] <= '0;
      end
    end else if (wr_file_res) begin
      file_reg[dec_bus.addr] <= result;
    end else if (wr_bit) begin
      file_reg[dec_bus.addr] <= bit_val;
    end
  end

  // Skip steps: taken test, discarded word, back to run
  sequence skip_taken_s;
    skip_now;
  endsequence

  sequence flush_cycle_s;
    state == st_flush && op == op_none;
  endsequence

  sequence back_to_run_s;
    state == st_run && !skip_active;
  endsequence

  sequence flags_held_s;
    $stable(result_null_flag) && $stable(overflow_out_bit) && $stable(nibble_carry);
  endsequence

  skip_two_cycle_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    skip_taken_s |=> flush_cycle_s ##1 back_to_run_s)
    else $error("skip did not flush exactly one word");

  skip_pulse_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    skip_taken_s |=> skip_active && instr_done)
    else $error("taken skip not reported");

  test_skip_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (op == op_tst_bit && fval[dec_bus.bsel]) |=> !skip_active && state == st_run)
    else $error("skip taken on set bit");

  flush_no_acc_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    state == st_flush |=> $stable(accumulator))
    else $error("discarded word changed accumulator");

  flush_no_flag_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    state == st_flush |=> flags_held_s)
    else $error("discarded word changed flags");

  flush_done_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    state == st_flush |=> instr_done && !skip_active)
    else $error("flush cycle not reported");

  done_one_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (instr_valid && state == st_run && !skip_now) |=> instr_done && state == st_run)
    else $error("instruction not single cycle");

  idle_no_done_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!instr_valid && state == st_run) |=> !instr_done)
    else $error("done pulse without a word");

  unknown_nop_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (instr_valid && state == st_run && op == op_none) |=> $stable(accumulator))
    else $error("unknown word changed accumulator");

  and_no_carry_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    is_and |=> $stable(overflow_out_bit) && $stable(nibble_carry))
    else $error("and changed carry");

  bit_no_flag_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_bit |=> flags_held_s)
    else $error("bit op changed flags");

  test_no_flag_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    op == op_tst_bit |=> flags_held_s)
    else $error("bit test changed flags");

  test_no_acc_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    op == op_tst_bit |=> $stable(accumulator))
    else $error("bit test changed accumulator");

  zero_flag_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (is_add || is_and) |=> result_null_flag == ($past(result) == '0))
    else $error("zero flag wrong");

  add_carry_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    is_add |=> overflow_out_bit ==
      (DATA_W'($past(accumulator) + $past(opnd)) < $past(accumulator)))
    else $error("carry wrong");

  nibble_carry_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    is_add |=> nibble_carry == (NIB_W'($past(accumulator[NIB_W-1:0]) +
      $past(opnd[NIB_W-1:0])) < $past(accumulator[NIB_W-1:0])))
    else $error("nibble carry wrong");

  acc_target_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_file_res |=> $stable(accumulator))
    else $error("file target wrote accumulator");

  acc_write_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_acc |=> accumulator == $past(result))
    else $error("accumulator not updated");

  file_write_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_file_res |=> file_reg[$past(dec_bus.addr)] == $past(result))
    else $error("file target not written");

  bit_write_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    op == op_set_bit |=> file_reg[$past(dec_bus.addr)][$past(dec_bus.bsel)])
    else $error("bit not set");

  bit_clear_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    op == op_clr_bit |=> !file_reg[$past(dec_bus.addr)][$past(dec_bus.bsel)])
    else $error("bit not cleared");

  bit_others_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_bit |=> ((file_reg[$past(dec_bus.addr)] ^ $past(fval)) & ~$past(bit_mask)) == '0)
    else $error("bit op changed other bits");

  lit_add_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    op == op_add_lit |=> accumulator == DATA_W'($past(accumulator) + $past(dec_bus.lit)))
    else $error("literal add wrong");

  lit_and_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    op == op_and_lit |=> accumulator == ($past(accumulator) & $past(dec_bus.lit)))
    else $error("literal and wrong");

  file_and_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (op == op_and_file && !dec_bus.tgt_file) |=>
      accumulator == ($past(accumulator) & $past(fval)))
    else $error("file and wrong");

  file_add_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (op == op_add_file && !dec_bus.tgt_file) |=>
      accumulator == DATA_W'($past(accumulator) + $past(fval)))
    else $error("file add wrong");
endmodule

/* File: bench/fetch_model.sv */
// Purpose: Fetch path model presenting instruction words to the execute block
// Assumes: One word per cycle, changed only just after a rising edge
// Notes: Idle bus shows an inverted pattern, not the last word
`timescale 1ns/1ps
module fetch_model
  import exec_pkg::*;
(
  input  wire logic               sys_clk,
  output logic [INSTR_W-1:0]      instr,
  output logic                    instr_valid
);
  initial begin
    instr = '0;
    instr_valid = 1'b0;
  end
  // Present a word at the next edge, or go idle
  task automatic drive(input logic [INSTR_W-1:0] w, input logic v);
    @(posedge sys_clk);
    instr <= v ? w : ~instr;
    instr_valid <= v;
  endtask
endmodule

/* File: bench/literal_file_bit_instr_exec_tb.sv */
// Purpose: Self-checking bench for the literal, file and bit execute block
// Assumes: File registers start at zero after reset
// Notes: Status byte packs skip, done, carry, nibble carry, zero
`timescale 1ns/1ps
module literal_file_bit_instr_exec_tb;
  import exec_pkg::*;
  logic               sys_clk;
  logic               reset;
  logic [INSTR_W-1:0] instr;
  logic               instr_valid;
  logic [DATA_W-1:0]  accumulator;
  logic               overflow_out_bit;
  logic               nibble_carry;
  logic               result_null_flag;
  logic               skip_active;
  logic               instr_done;
  int                 miscompares = 0;
  int                 cmp_count = 0;

  fetch_model fetch (.sys_clk(sys_clk), .instr(instr), .instr_valid(instr_valid));
  literal_file_bit_instr_exec uut (.sys_clk(sys_clk), .reset(reset), .instr(instr),
    .instr_valid(instr_valid), .accumulator(accumulator), .overflow_out_bit(overflow_out_bit),
    .nibble_carry(nibble_carry), .result_null_flag(result_null_flag),
    .skip_active(skip_active), .instr_done(instr_done));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic status(input logic [7:0] eacc, input logic [7:0] eflg);
    check("accumulator", eacc, accumulator);
    check("status", eflg, {3'h0, skip_active, instr_done, overflow_out_bit,
      nibble_carry, result_null_flag});
  endtask

  task automatic op(input logic [INSTR_W-1:0] w, input logic [7:0] eacc, input logic [7:0] eflg);
    fetch.drive(w, 1'b1);
    fetch.drive(w, 1'b0);
    #1;
    status(eacc, eflg);
  endtask

  task automatic t_literal;
    op(14'h3e15, 8'h15, 8'h08);
    op(14'h3eeb, 8'h00, 8'h0f);
    op(14'h3fa3, 8'ha3, 8'h08);
    op(14'h395f, 8'h03, 8'h08);
    op(14'h3a55, 8'h03, 8'h08);
    op(14'h3eff, 8'h02, 8'h0e);
  endtask

  task automatic t_bits;
    op(14'h17a2, 8'h02, 8'h0e);
    op(14'h1422, 8'h02, 8'h0e);
    op(14'h13a2, 8'h02, 8'h0e);
  endtask

  task automatic t_file;
    op(14'h07a2, 8'h02, 8'h08);
    op(14'h0522, 8'h02, 8'h08);
    op(14'h0722, 8'h05, 8'h08);
  endtask

  task automatic t_skip;
    op(14'h1822, 8'h05, 8'h08);
    fetch.drive(14'h1922, 1'b1);
    fetch.drive(14'h3e10, 1'b1);
    #1;
    status(8'h05, 8'h18);
    fetch.drive(14'h3e10, 1'b0);
    #1;
    status(8'h05, 8'h08);
    op(14'h3e10, 8'h15, 8'h08);
    op(14'h3900, 8'h00, 8'h09);
  endtask

  task automatic t_reset;
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    status(8'h00, 8'h00);
    op(14'h3e01, 8'h01, 8'h08);
    op(14'h0722, 8'h01, 8'h08);
  endtask

  task automatic t_burst;
    fetch.drive(14'h3e01, 1'b1);
    fetch.drive(14'h3e02, 1'b1);
    fetch.drive(14'h3e02, 1'b0);
    #1;
    status(8'h04, 8'h08);
  endtask

  task automatic test_done;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    status(8'h00, 8'h00);
    t_literal();
    t_bits();
    t_file();
    t_skip();
    t_reset();
    t_burst();
    test_done();
  end
endmodule
